// ### verilog/mbs_map.vh
// Constants shared by the serial protocol engine and its helpers
`ifndef MBS_MAP_VH
`define MBS_MAP_VH
// Time base
`define MBS_MS_NS 1000000
`define MBS_CLK_NS 10
// Trigger codes
`define MBS_TRIG_OFF 2'h0
`define MBS_TRIG_CYC 2'h1
`define MBS_TRIG_CHG 2'h2
// Endian swap codes
`define MBS_SWP_NONE 2'h0
`define MBS_SWP_BYTE 2'h1
`define MBS_SWP_WORD 2'h2
`define MBS_SWP_BW 2'h3
// Function codes
`define MBS_FC_RCOIL 8'h01
`define MBS_FC_RDISC 8'h02
`define MBS_FC_RHOLD 8'h03
`define MBS_FC_RINP 8'h04
`define MBS_FC_WCOIL 8'h05
`define MBS_FC_WREG 8'h06
`define MBS_FC_WCOILS 8'h0F
`define MBS_FC_WREGS 8'h10
`define MBS_FC_RWREGS 8'h17
// Quantity and interval limits
`define MBS_QTY_MIN 7'h01
`define MBS_RQTY_MAX 7'h7D
`define MBS_WQTY_MAX 7'h79
`define MBS_POLL_MIN 21'h00_01F4
`define MBS_POLL_MAX 21'h12_4F80
// Automatic gap settings in ms, used when a setting is zero
`define MBS_AUTO_ICT 8'h02
`define MBS_AUTO_IFD 8'h04
// ASCII framing characters
`define MBS_CH_COLON 8'h3A
`define MBS_CH_CR 8'h0D
`define MBS_CH_LF 8'h0A
// Frame layout
`define MBS_DATA_OFS 8'h03
`define MBS_HDR_RD 8'h06
`define MBS_HDR_SGL 8'h04
`define MBS_HDR_RW 8'h0A
`define MBS_PL_SGL 8'h02
`endif

// ### verilog/mbs_swap.v
// Endian swap of one four-byte group
`include "mbs_map.vh"
module mbs_swap (
    input wire [31:0] din, // Bytes A,B,C,D from high to low
    input wire [1:0] mode, // Swap selection
    output reg [31:0] dout // Reordered group
);
    reg [31:0] ph1;
    // Byte-and-word swap runs as two phases
    always @* begin
        ph1 = {din[23:16], din[31:24], din[7:0], din[15:8]};
        case (mode)
            `MBS_SWP_BYTE: dout = {din[7:0], din[15:8], din[23:16], din[31:24]};
            `MBS_SWP_WORD: dout = {din[15:0], din[31:16]};
            `MBS_SWP_BW: dout = {ph1[15:0], ph1[31:16]};
            default: dout = din;
        endcase
    end
endmodule // mbs_swap

// ### verilog/mbs_fifo.v
// Synchronous FIFO between frame delivery and the shared memory side
module mbs_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire mclk, // System clock
    input wire reset_n, // Synchronous reset, low active
    input wire in_valid, // Write request
    output wire in_ready, // Not full
    input wire [WIDTH-1:0] in_data, // Write data
    output wire out_valid, // Not empty
    input wire out_ready, // Read accept
    output wire [WIDTH-1:0] out_data // Head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wp_ff;
    reg [AW:0] rp_ff;
    wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = (wp_ff != rp_ff);
    assign out_data = mem[rp_ff[AW-1:0]];
    // Extra pointer bit tells full from empty
    always @(posedge mclk) begin
        if (!reset_n) begin
            wp_ff <= {(AW+1){1'b0}};
            rp_ff <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                mem[wp_ff[AW-1:0]] <= in_data;
                wp_ff <= wp_ff + 1'b1;
            end
            if (out_valid && out_ready)
                rp_ff <= rp_ff + 1'b1;
        end
    end
endmodule // mbs_fifo

// ### verilog/mbs_engine.v
// Serial RTU/ASCII protocol engine: slave receive, master command queue
// Operation
// - Slave framing is RTU or ASCII by choice
// - Slave accepts own station identifier or broadcast
// - Master sends RTU or ASCII framed requests
// - Master waits initial delay after boot
// - No response in timeout: abandon, continue
// - Timeout reissues request up to retry count
// - RTU character gap over limit discards frame
// - Zero character gap setting selects automatic value
// - RTU frame forwarded after inter-frame delay
// - Commands carry only the supported function codes
// - Disabled commands are never sent
// - Cyclic commands sent once per poll interval
// - Change commands sent only on data change
// - Swap none, byte reverse or word exchange on master RTU replies
// - Byte-word swap: halves' bytes, then halves
// - Start addresses are 16 bits wide
// - Read quantity 1 to 125 items
// - Write quantity 1 to 121 items
// - Reads go to memory, writes come from it
// - Serial data passes through shared memory side
`include "mbs_map.vh"
module mbs_engine #(
    parameter TICK_CYCLES = `MBS_MS_NS / `MBS_CLK_NS,
    parameter NCMD = 4,
    parameter CW = 2,
    parameter RX_DEPTH = 256,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire mclk, // 100 MHz clock
    input wire reset_n, // Synchronous reset, low active
    input wire master_mode, // 1 master, 0 slave
    input wire ascii_mode, // 1 ASCII framing, 0 RTU
    input wire [7:0] station_identifier, // Own slave address
    input wire [15:0] init_delay_ms, // Delay after boot
    input wire [13:0] resp_timeout_ms, // Response wait
    input wire [6:0] max_retry, // Reissues per request
    input wire [7:0] ict_ms, // Character gap limit, 0 auto
    input wire [7:0] ifd_ms, // Frame end delay, 0 auto
    output wire [CW-1:0] cmd_idx, // Selected command
    input wire [7:0] cmd_sid, // Command slave address
    input wire [7:0] cmd_fc, // Command function code
    input wire [1:0] cmd_trig, // Command trigger
    input wire [20:0] cmd_poll_ms, // Command poll interval
    input wire [1:0] cmd_swap, // Command endian swap
    input wire [15:0] cmd_raddr, // Read start address
    input wire [6:0] cmd_rqty, // Read quantity
    input wire [15:0] cmd_waddr, // Write start address
    input wire [6:0] cmd_wqty, // Write quantity
    input wire [31:0] cmd_sig, // Data area signature
    output wire [7:0] pl_idx, // Write payload byte index
    input wire [7:0] pl_byte, // Write payload byte
    input wire rx_valid, // Received character strobe
    input wire [7:0] rx_byte, // Received character
    output wire tx_valid, // Transmit character valid
    output wire [7:0] tx_byte, // Transmit character
    input wire tx_ready, // Transmitter accepts
    output wire up_valid, // Frame byte to memory side
    output wire [7:0] up_data, // Frame byte
    output wire up_last, // Last byte of frame
    input wire up_ready, // Memory side accepts
    output wire frame_drop, // Frame discarded pulse
    output wire cmd_fail, // Command refused or given up
    output wire busy // Master request in flight
);
    localparam M_INIT = 5'h01;
    localparam M_SCAN = 5'h02;
    localparam M_SEND = 5'h04;
    localparam M_WAIT = 5'h08;
    localparam M_DONE = 5'h10;

    function [3:0] hex2nib;
        input [7:0] c;
        begin
            hex2nib = (c >= 8'h41) ? (c[3:0] + 4'h9) : c[3:0];
        end
    endfunction

    function [7:0] nib2hex;
        input [3:0] n;
        begin
            nib2hex = (n > 4'h9) ? (8'h37 + {4'h0, n}) : (8'h30 + {4'h0, n});
        end
    endfunction

    // Millisecond tick shared by every timer
    reg [16:0] tick_cnt_ff;
    wire tick = (tick_cnt_ff == TICK_CYCLES - 1);
    always @(posedge mclk) begin
        if (!reset_n)
            tick_cnt_ff <= 17'h0_0000;
        else
            tick_cnt_ff <= tick ? 17'h0_0000 : tick_cnt_ff + 1'b1;
    end

    // Receive side state
    reg [7:0] rbuf [0:RX_DEPTH-1];
    reg [7:0] gap_ff;
    reg [7:0] cnt_ff;
    reg in_frm_ff;
    reg bad_ff;
    reg cr_ff;
    reg done_ff;
    reg drop_ff;
    reg dlv_ff;
    reg [7:0] rd_ff;
    reg [7:0] len_ff;
    reg [1:0] dswap_ff;
    reg [4:0] st_ff;
    wire [7:0] ict_lim = (ict_ms == 8'h00) ? `MBS_AUTO_ICT : ict_ms;
    wire [7:0] ifd_lim = (ifd_ms == 8'h00) ? `MBS_AUTO_IFD : ifd_ms;
    wire rx_take = rx_valid && !dlv_ff;

    // Frame assembly; the buffer is not reused while a frame drains
    always @(posedge mclk) begin
        if (!reset_n) begin
            gap_ff <= 8'h00;
            cnt_ff <= 8'h00;
            in_frm_ff <= 1'b0;
            bad_ff <= 1'b0;
            cr_ff <= 1'b0;
            done_ff <= 1'b0;
            drop_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            drop_ff <= 1'b0;
            if (tick && gap_ff != 8'hFF)
                gap_ff <= gap_ff + 1'b1;
            if (ascii_mode) begin
                if (rx_take) begin
                    if (rx_byte == `MBS_CH_COLON) begin
                        in_frm_ff <= 1'b1;
                        cnt_ff <= 8'h00;
                        cr_ff <= 1'b0;
                        bad_ff <= 1'b0;
                    end else if (in_frm_ff) begin
                        cr_ff <= (rx_byte == `MBS_CH_CR);
                        if (cr_ff && rx_byte == `MBS_CH_LF) begin
                            in_frm_ff <= 1'b0;
                            done_ff <= !bad_ff;
                            drop_ff <= bad_ff;
                        end else if (rx_byte != `MBS_CH_CR) begin
                            if (cnt_ff == RX_DEPTH - 1)
                                bad_ff <= 1'b1;
                            else begin
                                rbuf[cnt_ff] <= rx_byte;
                                cnt_ff <= cnt_ff + 1'b1;
                            end
                        end
                    end
                end
            end else if (rx_take) begin
                gap_ff <= 8'h00;
                in_frm_ff <= 1'b1;
                // Late character spoils the whole frame
                if (in_frm_ff && gap_ff > ict_lim)
                    bad_ff <= 1'b1;
                else if (!bad_ff && cnt_ff != RX_DEPTH - 1) begin
                    rbuf[cnt_ff] <= rx_byte;
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end else if (in_frm_ff && gap_ff >= ifd_lim) begin
                // Silence for the frame delay closes the frame
                in_frm_ff <= 1'b0;
                done_ff <= !bad_ff && cnt_ff != 8'h00;
                drop_ff <= bad_ff;
                bad_ff <= 1'b0;
                // A good frame keeps its count until delivery latches it
                if (bad_ff)
                    cnt_ff <= 8'h00;
            end
            if (done_ff)
                cnt_ff <= 8'h00;
        end
    end

    // Address of a finished frame; ASCII carries it as two hex digits
    wire [7:0] fr_addr = ascii_mode ? {hex2nib(rbuf[0]), hex2nib(rbuf[1])} : rbuf[0];
    wire slv_hit = !master_mode && (fr_addr == station_identifier ||
        fr_addr == 8'h00);
    wire mst_hit = master_mode && st_ff == M_WAIT && fr_addr == cmd_sid;
    wire fr_take = done_ff && (slv_hit || mst_hit) && !dlv_ff;

    // Delivery with endian swap over four-byte data groups of master RTU replies
    wire fifo_rdy;
    wire [7:0] rel = rd_ff - `MBS_DATA_OFS;
    wire [7:0] gbase = `MBS_DATA_OFS + {rel[7:2], 2'b00};
    wire in_grp = (rd_ff >= `MBS_DATA_OFS) && (gbase + 8'h03 < len_ff);
    wire [31:0] grp = {rbuf[gbase], rbuf[gbase + 8'h01], rbuf[gbase + 8'h02],
        rbuf[gbase + 8'h03]};
    wire [31:0] grp_sw;
    wire [7:0] sw_byte = grp_sw[8'd31 - {3'h0, rel[1:0], 3'h0} -: 8];
    wire [7:0] dlv_byte = in_grp ? sw_byte : rbuf[rd_ff];
    wire dlv_last = (rd_ff == len_ff - 8'h01);

    mbs_swap u_swap (
        .din(grp),
        .mode(dswap_ff),
        .dout(grp_sw)
    );

    always @(posedge mclk) begin
        if (!reset_n) begin
            dlv_ff <= 1'b0;
            rd_ff <= 8'h00;
            len_ff <= 8'h00;
            dswap_ff <= `MBS_SWP_NONE;
        end else if (fr_take) begin
            dlv_ff <= 1'b1;
            rd_ff <= 8'h00;
            len_ff <= cnt_ff;
            dswap_ff <= (master_mode && !ascii_mode) ? cmd_swap : `MBS_SWP_NONE;
        end else if (dlv_ff && fifo_rdy) begin
            rd_ff <= rd_ff + 1'b1;
            if (dlv_last)
                dlv_ff <= 1'b0;
        end
    end

    mbs_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(dlv_ff),
        .in_ready(fifo_rdy),
        .in_data({dlv_last, dlv_byte}),
        .out_valid(up_valid),
        .out_ready(up_ready),
        .out_data({up_last, up_data})
    );

    // Command checks and request layout
    wire fc_rd = (cmd_fc >= `MBS_FC_RCOIL && cmd_fc <= `MBS_FC_RINP);
    wire fc_sgl = (cmd_fc == `MBS_FC_WCOIL || cmd_fc == `MBS_FC_WREG);
    wire fc_mul = (cmd_fc == `MBS_FC_WCOILS || cmd_fc == `MBS_FC_WREGS);
    wire fc_rw = (cmd_fc == `MBS_FC_RWREGS);
    wire rq_ok = cmd_rqty >= `MBS_QTY_MIN && cmd_rqty <= `MBS_RQTY_MAX;
    wire wq_ok = cmd_wqty >= `MBS_QTY_MIN && cmd_wqty <= `MBS_WQTY_MAX;
    wire cmd_ok = (fc_rd && rq_ok) || fc_sgl || (fc_mul && wq_ok) ||
        (fc_rw && rq_ok && wq_ok);
    wire [20:0] poll_lim = (cmd_poll_ms < `MBS_POLL_MIN) ? `MBS_POLL_MIN :
        (cmd_poll_ms > `MBS_POLL_MAX) ? `MBS_POLL_MAX : cmd_poll_ms;
    wire [7:0] hlen = fc_rw ? `MBS_HDR_RW : fc_sgl ? `MBS_HDR_SGL : `MBS_HDR_RD;
    wire [7:0] plen = fc_sgl ? `MBS_PL_SGL :
        (cmd_fc == `MBS_FC_WCOILS) ? ({1'b0, cmd_wqty} + 8'h07) >> 3 :
        (fc_mul || fc_rw) ? {cmd_wqty, 1'b0} : 8'h00;
    wire has_bc = fc_mul || fc_rw;
    wire [7:0] blen = hlen + {7'h00, has_bc} + plen;
    wire [8:0] nch = ascii_mode ? {blen, 1'b0} + 9'h003 : {1'b0, blen};

    // Byte and character picked for position t of the request
    reg [8:0] t_ff;
    wire [8:0] tb = ascii_mode ? (t_ff - 9'h001) >> 1 : t_ff;
    wire [7:0] bi = tb[7:0];
    wire [7:0] wfa = fc_rw ? 8'h06 : 8'h02; // Write address position
    reg [7:0] req_byte;
    always @* begin
        case (bi)
            8'h00: req_byte = cmd_sid;
            8'h01: req_byte = cmd_fc;
            8'h02: req_byte = fc_rd || fc_rw ? cmd_raddr[15:8] : cmd_waddr[15:8];
            8'h03: req_byte = fc_rd || fc_rw ? cmd_raddr[7:0] : cmd_waddr[7:0];
            8'h04: req_byte = fc_rd || fc_rw ? 8'h00 : 8'h00;
            8'h05: req_byte = fc_rd || fc_rw ? {1'b0, cmd_rqty} : {1'b0, cmd_wqty};
            default: req_byte = plen;
        endcase
        if (fc_sgl && bi >= hlen)
            req_byte = pl_byte;
        else if (fc_rw && (bi == wfa || bi == wfa + 8'h01))
            req_byte = (bi == wfa) ? cmd_waddr[15:8] : cmd_waddr[7:0];
        else if (fc_rw && bi == 8'h08)
            req_byte = 8'h00;
        else if (fc_rw && bi == 8'h09)
            req_byte = {1'b0, cmd_wqty};
        else if (has_bc && bi > hlen)
            req_byte = pl_byte;
    end
    assign pl_idx = bi - hlen - {7'h00, has_bc};
    wire [8:0] tl = t_ff + 9'h002;
    wire [7:0] req_char = !ascii_mode ? req_byte :
        (t_ff == 9'h000) ? `MBS_CH_COLON :
        (tl == nch) ? `MBS_CH_CR : (tl == nch + 9'h001) ? `MBS_CH_LF :
        t_ff[0] ? nib2hex(req_byte[7:4]) : nib2hex(req_byte[3:0]);

    // Master sequencer and per-command poll timers
    reg [CW-1:0] idx_ff;
    reg [20:0] ptmr_ff [0:NCMD-1];
    reg [31:0] lsig_ff [0:NCMD-1];
    reg [15:0] tmr_ff;
    reg [6:0] retry_ff;
    reg txv_ff;
    reg [7:0] txb_ff;
    reg fail_ff;
    integer i;
    wire due = ptmr_ff[idx_ff] >= poll_lim;
    wire tx_go = !txv_ff || tx_ready;
    assign cmd_idx = idx_ff;
    assign tx_valid = txv_ff;
    assign tx_byte = txb_ff;
    assign frame_drop = drop_ff;
    assign cmd_fail = fail_ff;
    assign busy = (st_ff == M_SEND) || (st_ff == M_WAIT);

    always @(posedge mclk) begin
        if (!reset_n) begin
            st_ff <= M_INIT;
            idx_ff <= {CW{1'b0}};
            tmr_ff <= 16'h0000;
            retry_ff <= 7'h00;
            t_ff <= 9'h000;
            txv_ff <= 1'b0;
            txb_ff <= 8'h00;
            fail_ff <= 1'b0;
            for (i = 0; i < NCMD; i = i + 1) begin
                ptmr_ff[i] <= 21'h00_0000;
                lsig_ff[i] <= 32'h0000_0000;
            end
        end else begin
            fail_ff <= 1'b0;
            if (txv_ff && tx_ready)
                txv_ff <= 1'b0;
            for (i = 0; i < NCMD; i = i + 1)
                if (tick && ptmr_ff[i] != `MBS_POLL_MAX)
                    ptmr_ff[i] <= ptmr_ff[i] + 1'b1;
            if (tick && tmr_ff != 16'hFFFF)
                tmr_ff <= tmr_ff + 1'b1;
            case (st_ff)
                M_INIT: begin
                    // No request leaves before the boot delay runs out
                    if (tmr_ff >= init_delay_ms && master_mode)
                        st_ff <= M_SCAN;
                end
                M_SCAN: begin
                    retry_ff <= 7'h00;
                    t_ff <= 9'h000;
                    tmr_ff <= 16'h0000;
                    if (!master_mode)
                        st_ff <= M_SCAN;
                    else if (cmd_trig == `MBS_TRIG_OFF || !due)
                        idx_ff <= idx_ff + 1'b1;
                    else if (!cmd_ok) begin
                        fail_ff <= 1'b1;
                        ptmr_ff[idx_ff] <= 21'h00_0000;
                        idx_ff <= idx_ff + 1'b1;
                    end else if (cmd_trig == `MBS_TRIG_CYC) begin
                        ptmr_ff[idx_ff] <= 21'h00_0000;
                        st_ff <= M_SEND;
                    end else begin
                        // Data area checked each interval, sent on change
                        ptmr_ff[idx_ff] <= 21'h00_0000;
                        lsig_ff[idx_ff] <= cmd_sig;
                        if (cmd_sig != lsig_ff[idx_ff])
                            st_ff <= M_SEND;
                        else
                            idx_ff <= idx_ff + 1'b1;
                    end
                end
                M_SEND: begin
                    if (tx_go && t_ff != nch) begin
                        txv_ff <= 1'b1;
                        txb_ff <= req_char;
                        t_ff <= t_ff + 1'b1;
                    end else if (tx_go) begin
                        tmr_ff <= 16'h0000;
                        st_ff <= (cmd_sid == 8'h00) ? M_DONE : M_WAIT;
                    end
                end
                M_WAIT: begin
                    if (fr_take)
                        st_ff <= M_DONE;
                    else if (tmr_ff >= {2'b00, resp_timeout_ms}) begin
                        t_ff <= 9'h000;
                        if (retry_ff < max_retry) begin
                            retry_ff <= retry_ff + 1'b1;
                            st_ff <= M_SEND;
                        end else begin
                            fail_ff <= 1'b1;
                            st_ff <= M_DONE;
                        end
                    end
                end
                M_DONE: begin
                    idx_ff <= idx_ff + 1'b1;
                    st_ff <= M_SCAN;
                end
                default: st_ff <= M_INIT;
            endcase
        end
    end
endmodule // mbs_engine

// ### bench/mbs_engine_monitor.sv
// Port-level assertions for the serial protocol engine
module mbs_engine_monitor #(
    parameter TICK_CYCLES = 100000
) (
    input wire logic mclk, // Clock
    input wire logic reset_n, // Reset, low active
    input wire logic master_mode, // Mode
    input wire logic [15:0] init_delay_ms, // Boot delay
    input wire logic [1:0] cmd_idx, // Command
    input wire logic tx_valid, // Tx valid
    input wire logic [7:0] tx_byte, // Tx char
    input wire logic tx_ready, // Tx accept
    input wire logic up_valid, // Up valid
    input wire logic [7:0] up_data, // Up byte
    input wire logic up_last, // Up last
    input wire logic up_ready, // Up accept
    input wire logic frame_drop, // Drop pulse
    input wire logic cmd_fail, // Fail pulse
    input wire logic busy // In flight
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] since_ff;
    // Cycles since reset; saturates so a long run never wraps
    always_ff @(posedge mclk) begin
        if (!reset_n) since_ff <= 32'h0000_0000;
        else if (~&since_ff) since_ff <= since_ff + 32'h0000_0001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx char not held");
    property p_up_hold; up_valid && !up_ready |=> up_valid && $stable(up_data); endproperty
    a_up_hold: assert property (p_up_hold) else $error("up byte not held");
    property p_drop_one; frame_drop |=> !frame_drop; endproperty
    a_drop_one: assert property (p_drop_one) else $error("drop pulse too long");
    property p_fail_one; cmd_fail |=> !cmd_fail; endproperty
    a_fail_one: assert property (p_fail_one) else $error("fail pulse too long");
    property p_slave_quiet; !master_mode |-> !tx_valid && !busy; endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("slave transmits");
    // Slack of two cycles covers the scan step between delay end and send
    property p_init; tx_valid |-> since_ff + 2 >= init_delay_ms * TICK_CYCLES; endproperty
    a_init: assert property (p_init) else $error("request before boot delay");
    property p_tx_busy; tx_valid |-> busy; endproperty
    a_tx_busy: assert property (p_tx_busy) else $error("tx while idle");
    property p_idx_hold; busy ##1 busy |-> $stable(cmd_idx); endproperty
    a_idx_hold: assert property (p_idx_hold) else $error("command changed in flight");
    c_drop: cover property (frame_drop);
    c_fail: cover property (cmd_fail);
    c_last: cover property (up_valid && up_ready && up_last);
endmodule // mbs_engine_monitor

// ### bench/mbs_peer.sv
// Far-side serial device model: takes requests, answers on demand
module mbs_peer (
    input wire logic mclk, // Clock
    input wire logic slow, // Stall acceptance
    input wire logic tx_valid, // Request valid
    input wire logic [7:0] tx_byte, // Request char
    output logic tx_ready, // Char accepted
    output logic rx_valid, // Answer strobe
    output logic [7:0] rx_byte // Answer char
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic ph = 1'b0;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // Slow mode accepts every other cycle to make the engine hold its char
    always @(posedge mclk) begin
        ph <= ~ph;
        tx_ready <= !slow || ph;
        if (tx_valid && tx_ready) got.push_back(tx_byte);
    end
    // Released line shows the inverse so no stale value reads as data
    task automatic send(input logic [7:0] b, input int gap);
        repeat (gap) @(posedge mclk);
        rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
endmodule // mbs_peer

// ### bench/mbs_engine_tb.sv
// Self-checking bench of the serial protocol engine
`include "mbs_map.vh"
module mbs_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, reset_n = 0, mm = 0, am = 0, slow = 0, up_ready = 0, lst, seen;
    logic [7:0] sid = 8'h05, ict = 0, ifd = 0, fc = 8'h03, pl_idx, tx_byte, up_data, rx_byte;
    logic [1:0] trig = 0, swap = 0, cmd_idx;
    logic [13:0] tmo = 14'h0064;
    logic [6:0] retry = 0;
    logic [31:0] sig = 0;
    logic tx_valid, tx_ready, rx_valid, up_valid, up_last, frame_drop, cmd_fail, busy;
    logic [7:0] q[$];
    int fail_count = 0, n_tests = 0, k;
    initial forever #5 mclk = ~mclk;
    mbs_peer peer (.mclk, .slow, .tx_valid, .tx_byte, .tx_ready, .rx_valid, .rx_byte);
    // One ms is ten cycles so timeouts and polls stay short
    mbs_engine #(.TICK_CYCLES(10)) dut (.mclk, .reset_n, .master_mode(mm), .ascii_mode(am),
        .station_identifier(sid), .init_delay_ms(16'h0003), .resp_timeout_ms(tmo),
        .max_retry(retry), .ict_ms(ict), .ifd_ms(ifd), .cmd_idx, .cmd_sid(sid), .cmd_fc(fc),
        .cmd_trig(cmd_idx == 2'h0 ? trig : `MBS_TRIG_OFF), .cmd_poll_ms(`MBS_POLL_MIN),
        .cmd_swap(swap), .cmd_raddr({8'h12, sid}), .cmd_rqty(7'h02), .cmd_waddr({8'h56, sid}),
        .cmd_wqty(7'h02), .cmd_sig(sig), .pl_idx, .pl_byte(pl_idx ^ 8'hA5), .rx_valid,
        .rx_byte, .tx_valid, .tx_byte, .tx_ready, .up_valid, .up_data, .up_last, .up_ready,
        .frame_drop, .cmd_fail, .busy);
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Every open-ended wait goes through here so a hang ends the run; fixed repeat waits do not
    task automatic step;
        @(posedge mclk);
        if (++k > 9000) begin
            chk(0, 1);
            wrap_up;
        end
    endtask
    task automatic cmpq(input logic [7:0] g[$], input logic [7:0] e[$]);
        chk(g.size(), e.size());
        foreach (e[i]) chk(g[i], e[i]);
    endtask
    task automatic rst(input logic m, input logic a);
        @(posedge mclk);
        reset_n <= 0;
        mm <= m;
        am <= a;
        repeat (5) @(posedge mclk);
        reset_n <= 1;
        peer.got.delete();
        k = 0;
    endtask
    task automatic send(input logic [7:0] b[$], input int gap);
        foreach (b[i]) peer.send(b[i], gap);
    endtask
    task automatic take(input int n);
        q.delete();
        up_ready <= 1;
        k = 0;
        while (q.size() < n) begin
            step;
            if (up_valid === 1'b1) q.push_back(up_data);
            if (up_valid === 1'b1) lst = up_last;
        end
        up_ready <= 0;
        chk(lst, 1);
    endtask
    task automatic quiet(input int n);
        seen = 0;
        repeat (n) @(posedge mclk) seen |= up_valid;
        chk(seen, 0);
    endtask
    task automatic t_slave;
        rst(0, 0);
        send('{8'h05, 8'h03, 8'h55}, 2);
        repeat (80) @(posedge mclk);
        take(3);
        cmpq(q, '{8'h05, 8'h03, 8'h55});
        send('{8'h00, 8'h06, 8'h66}, 2);
        take(3);
        cmpq(q, '{8'h00, 8'h06, 8'h66});
        send('{8'h09, 8'h03, 8'h77}, 2);
        quiet(120);
        ict <= 1;
        ifd <= 6;
        rst(0, 0);
        send('{8'h05}, 2);
        peer.send(8'h03, 35);
        for (k = 0; frame_drop !== 1'b1;) step;
        quiet(20);
        ict <= 0;
        ifd <= 0;
        $display("slave receive done");
    endtask
    task automatic t_master;
        logic [7:0] e[4][4] = '{'{8'h0A, 8'h0B, 8'h0C, 8'h0D}, '{8'h0D, 8'h0C, 8'h0B, 8'h0A},
            '{8'h0C, 8'h0D, 8'h0A, 8'h0B}, '{8'h0D, 8'h0C, 8'h0B, 8'h0A}};
        sid <= 8'h07;
        trig <= `MBS_TRIG_CYC;
        for (int m = 0; m < 4; m++) begin
            swap <= 2'(m);
            slow <= m[0];
            rst(1, 0);
            while (peer.got.size() < 6) step;
            cmpq(peer.got, '{8'h07, 8'h03, 8'h12, 8'h07, 8'h00, 8'h02});
            send('{8'h07, 8'h03, 8'h04, 8'h0A, 8'h0B, 8'h0C, 8'h0D}, 1);
            take(7);
            for (int i = 0; i < 4; i++) chk(q[3 + i], e[m][i]);
        end
        slow <= 0;
        rst(1, 1);
        while (peer.got.size() < 15) step;
        cmpq(peer.got, '{8'h3A, 8'h30, 8'h37, 8'h30, 8'h33, 8'h31, 8'h32, 8'h30, 8'h37,
            8'h30, 8'h30, 8'h30, 8'h32, 8'h0D, 8'h0A});
        $display("master framing done");
    endtask
    task automatic t_queue;
        tmo <= 2;
        retry <= 1;
        rst(1, 0);
        while (cmd_fail !== 1'b1) step;
        chk(peer.got.size(), 12);
        tmo <= 100;
        fc <= 8'h07;
        rst(1, 0);
        while (cmd_fail !== 1'b1) step;
        chk(peer.got.size(), 0);
        fc <= 8'h03;
        trig <= `MBS_TRIG_OFF;
        rst(1, 0);
        repeat (5200) @(posedge mclk);
        chk(peer.got.size(), 0);
        trig <= `MBS_TRIG_CHG;
        fc <= 8'h10;
        rst(1, 0);
        repeat (5200) @(posedge mclk);
        chk(peer.got.size(), 0);
        sig <= 32'h0000_0001;
        while (peer.got.size() < 11) step;
        cmpq(peer.got, '{8'h07, 8'h10, 8'h56, 8'h07, 8'h00, 8'h02, 8'h04, 8'hA5, 8'hA4, 8'hA7,
            8'hA6});
        $display("command queue done");
    endtask
    initial begin
        t_slave;
        t_master;
        t_queue;
        wrap_up;
    end
endmodule // mbs_engine_tb
bind mbs_engine mbs_engine_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.mclk, .reset_n,
    .master_mode, .init_delay_ms, .cmd_idx, .tx_valid, .tx_byte, .tx_ready, .up_valid,
    .up_data, .up_last, .up_ready, .frame_drop, .cmd_fail, .busy);
